// File: design/pmg_defs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes a 100 MHz aclk and a 24-bit two's complement sample stream
`ifndef PMG_DEFS_SVH
`define PMG_DEFS_SVH
// Byte offsets of the registers
`define PMG_VOL_OFS   12'h410
`define PMG_STAT_OFS  12'h414
`define PMG_FILT_OFS  12'h420
`define PMG_GATE_OFS  12'h430
// Playback filter control fields
`define PMG_MUTE_BIT  9
`define PMG_MONO_BIT  7
`define PMG_RATE_BIT  5
`define PMG_URAMP_BIT 4
`define PMG_FILT_RST  16'h0200
// Noise gate control fields
`define PMG_HLD_LSB   5
`define PMG_THR_LSB   1
`define PMG_ENA_BIT   0
`define PMG_GATE_RST  16'h0068
// Volume register: left in low byte, right in high byte
`define PMG_VOL_RST   16'hc0c0
`define PMG_VOL_0DB   8'hc0
// Samples per gain step of the ramp
`define PMG_FAST_SMP  6'd2
`define PMG_SLOW_SMP  6'd32
// Gate hold times in ms, and clock rate in kHz
`define PMG_HLD0_MS   30
`define PMG_HLD1_MS   125
`define PMG_HLD2_MS   250
`define PMG_HLD3_MS   500
`define PMG_CLK_KHZ   100000
`define PMG_MS2CYC(ms) ((ms) * `PMG_CLK_KHZ)
// Gate level for -60 dBFS on a 24-bit scale; each code step halves it
`define PMG_THR_TOP   24'd8389
// Fraction bits of the gain mantissa
`define PMG_MANT_FRAC 14
`endif

// File: design/pmg_pkg.sv
// Shared types of the playback mute and gate path
// Assumes pmg_defs.svh holds the numbers
package pmg_pkg;
  typedef logic signed [23:0] pmg_smp_t;
  typedef logic [7:0]         pmg_code_t;
endpackage : pmg_pkg

// File: design/pmg_gain_stage.sv
// One channel of gain: volume code to linear gain, registered result
// Assumes code follows 0.375 dB steps, 0 is mute, c0h and above is 0 dB
`timescale 1ns/1ps
`include "pmg_defs.svh"
module pmg_gain_stage
  import pmg_pkg::*;
(
  // Clock and reset
  input  wire logic      aclk,
  input  wire logic      aresetn,
  // Sample and gain code
  input  wire logic      in_vld,
  input  wire pmg_smp_t  in_smp,
  input  wire pmg_code_t code,
  // Scaled sample
  output pmg_smp_t       out_smp
);
  // 2^(-k/16) in Q14; sixteen steps of 0.375 dB make one 6 dB shift
  function automatic logic [14:0] mant(input logic [3:0] k);
    case (k)
      4'h0:    mant = 15'd16384;
      4'h1:    mant = 15'd15689;
      4'h2:    mant = 15'd15024;
      4'h3:    mant = 15'd14386;
      4'h4:    mant = 15'd13777;
      4'h5:    mant = 15'd13193;
      4'h6:    mant = 15'd12634;
      4'h7:    mant = 15'd12098;
      4'h8:    mant = 15'd11585;
      4'h9:    mant = 15'd11094;
      4'ha:    mant = 15'd10624;
      4'hb:    mant = 15'd10173;
      4'hc:    mant = 15'd9742;
      4'hd:    mant = 15'd9329;
      4'he:    mant = 15'd8933;
      default: mant = 15'd8555;
    endcase
  endfunction : mant

  logic [7:0]         att;
  logic signed [39:0] prod;
  logic signed [39:0] shf;

  always_comb begin
    att  = (code >= `PMG_VOL_0DB) ? 8'h00 : 8'(`PMG_VOL_0DB - code);
    prod = (40'(in_smp) * 40'(signed'({1'b0, mant(att[3:0])}))) >>> `PMG_MANT_FRAC;
    shf  = prod >>> att[7:4];
  end

  // Gain never exceeds one, so the low 24 bits hold the whole result
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_smp <= '0;
    end else if (in_vld) begin
      out_smp <= (code == 8'h00) ? '0 : shf[23:0];
    end
  end
endmodule : pmg_gain_stage

// File: design/pmg_noise_gate.sv
// Noise gate detector: level compare and hold timer
// Assumes samples from the same clock domain, level held between samples
`timescale 1ns/1ps
`include "pmg_defs.svh"
module pmg_noise_gate
  import pmg_pkg::*;
#(
  parameter int unsigned HOLD_W = 26,
  parameter int unsigned HOLD0  = 3000000,
  parameter int unsigned HOLD1  = 12500000,
  parameter int unsigned HOLD2  = 25000000,
  parameter int unsigned HOLD3  = 50000000
) (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Settings
  input  wire logic       ena,
  input  wire logic [2:0] thr,
  input  wire logic [1:0] hld,
  // Samples
  input  wire logic       in_vld,
  input  wire pmg_smp_t   in_l,
  input  wire pmg_smp_t   in_r,
  // Gate state
  output logic            active
);
  function automatic logic [23:0] mag(input pmg_smp_t x);
    mag = x[23] ? 24'(-x) : 24'(x);
  endfunction : mag

  logic [23:0]       lvl;
  logic              loud;
  logic [HOLD_W-1:0] hold_cyc;
  logic [HOLD_W-1:0] cnt_q;

  always_comb begin
    lvl  = `PMG_THR_TOP >> thr;
    loud = in_vld && (mag(in_l) >= lvl || mag(in_r) >= lvl);
    case (hld)
      2'b00:   hold_cyc = HOLD_W'(HOLD0);
      2'b01:   hold_cyc = HOLD_W'(HOLD1);
      2'b10:   hold_cyc = HOLD_W'(HOLD2);
      default: hold_cyc = HOLD_W'(HOLD3);
    endcase
  end

  // Any loud sample restarts the quiet count
  always_ff @(posedge aclk) begin
    if (!aresetn || !ena || loud) begin
      cnt_q <= '0;
    end else if (cnt_q < hold_cyc) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Activates one cycle after the full hold has passed, i.e. strictly longer
  always_ff @(posedge aclk) begin
    if (!aresetn || !ena) begin
      active <= 1'b0;
    end else if (loud) begin
      active <= 1'b0;
    end else if (cnt_q >= hold_cyc) begin
      active <= 1'b1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_GATE_OFF: assert property (!ena |=> !active && cnt_q == '0)
    else $error("gate active while disabled");
  AST_GATE_WAIT: assert property ($rose(active) |-> $past(cnt_q) >= $past(hold_cyc))
    else $error("gate fired before hold time");
  AST_GATE_LOUD: assert property (loud |=> cnt_q == '0 && !active)
    else $error("loud sample did not restart hold");
  AST_THR_RANGE: assert property (lvl <= `PMG_THR_TOP && lvl >= (`PMG_THR_TOP >> 7))
    else $error("gate level out of range");
endmodule : pmg_noise_gate

// File: design/pmg_playback_path.sv
// Playback path soft mute, noise gate and mono mix behind an AXI4-Lite slave
// Assumes samples arrive as one-cycle strobes from logic on aclk
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "pmg_defs.svh"
module pmg_playback_path
  import pmg_pkg::*;
#(
  parameter int unsigned ADDR_W    = 12,
  parameter int unsigned HOLD_W    = 26,
  parameter int unsigned HOLD0_CYC = `PMG_MS2CYC(`PMG_HLD0_MS),
  parameter int unsigned HOLD1_CYC = `PMG_MS2CYC(`PMG_HLD1_MS),
  parameter int unsigned HOLD2_CYC = `PMG_MS2CYC(`PMG_HLD2_MS),
  parameter int unsigned HOLD3_CYC = `PMG_MS2CYC(`PMG_HLD3_MS)
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // AXI4-Lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  // AXI4-Lite read data
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Samples in
  input  wire logic              in_valid,
  input  wire pmg_smp_t          in_left,
  input  wire pmg_smp_t          in_right,
  // Samples out
  output logic                   out_valid,
  output pmg_smp_t               out_left,
  output pmg_smp_t               out_right
);
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Register state
  logic [15:0]       filt_q;
  logic [15:0]       gate_q;
  logic [15:0]       vol_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              wr_do;
  logic              wr_filt;
  logic              wr_gate;
  logic              wr_vol;

  // Path state
  logic              eff_mute;
  logic              gate_act;
  logic [4:0]        smp_cnt_q;
  logic [4:0]        lim;
  logic              step_tick;
  logic [24:0]       sum;
  logic              mix_vld_q;
  logic [15:0]       cur_all;
  logic [15:0]       tgt_all;
  pmg_smp_t          mix_l;
  pmg_smp_t          mix_r;

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  function automatic logic [ADDR_W-1:0] word(input logic [ADDR_W-1:0] a);
    word = {a[ADDR_W-1:2], 2'b00};
  endfunction : word

  // Write address and data are taken in either order, then joined
  assign wr_do   = !awready && !wready && !bvalid;
  assign wr_filt = wr_do && word(aw_addr_q) == ADDR_W'(`PMG_FILT_OFS);
  assign wr_gate = wr_do && word(aw_addr_q) == ADDR_W'(`PMG_GATE_OFS);
  assign wr_vol  = wr_do && word(aw_addr_q) == ADDR_W'(`PMG_VOL_OFS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b1;
      aw_addr_q <= '0;
    end else if (awvalid && awready) begin
      awready   <= 1'b0;
      aw_addr_q <= awaddr;
    end else if (wr_do) begin
      awready   <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready   <= 1'b1;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (wvalid && wready) begin
      wready   <= 1'b0;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (wr_do) begin
      wready   <= 1'b1;
    end
  end

  // The status word is read-only; a write there is refused like a hole
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_do) begin
      bvalid <= 1'b1;
      bresp  <= (wr_filt || wr_gate || wr_vol) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt_q <= `PMG_FILT_RST;
      gate_q <= `PMG_GATE_RST;
      vol_q  <= `PMG_VOL_RST;
    end else begin
      if (wr_filt) begin
        filt_q <= merge(filt_q, w_data_q, w_strb_q) & 16'h02b0;
      end
      if (wr_gate) begin
        gate_q <= merge(gate_q, w_data_q, w_strb_q) & 16'h006f;
      end
      if (wr_vol) begin
        vol_q <= merge(vol_q, w_data_q, w_strb_q);
      end
    end
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= RESP_OKAY;
      case (word(araddr))
        ADDR_W'(`PMG_FILT_OFS): rdata <= {16'h0000, filt_q};
        ADDR_W'(`PMG_GATE_OFS): rdata <= {16'h0000, gate_q};
        ADDR_W'(`PMG_VOL_OFS):  rdata <= {16'h0000, vol_q};
        ADDR_W'(`PMG_STAT_OFS): rdata <= {15'h0000, gate_act, cur_all};
        default: begin
          rdata <= '0;
          rresp <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Noise gate
  pmg_noise_gate #(
    .HOLD_W (HOLD_W),
    .HOLD0  (HOLD0_CYC),
    .HOLD1  (HOLD1_CYC),
    .HOLD2  (HOLD2_CYC),
    .HOLD3  (HOLD3_CYC)
  ) u_gate (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ena     (gate_q[`PMG_ENA_BIT]),
    .thr     (gate_q[`PMG_THR_LSB +: 3]),
    .hld     (gate_q[`PMG_HLD_LSB +: 2]),
    .in_vld  (in_valid),
    .in_l    (in_left),
    .in_r    (in_right),
    .active  (gate_act)
  );

  assign eff_mute = filt_q[`PMG_MUTE_BIT] || gate_act;

  // Ramp pacing counts samples, so the ramp time scales with fs
  assign lim       = filt_q[`PMG_RATE_BIT] ? 5'(`PMG_SLOW_SMP - 6'd1) : 5'(`PMG_FAST_SMP - 6'd1);
  assign step_tick = in_valid && smp_cnt_q == lim;

  // Cleared on a filter write so a rate change never overshoots the limit
  always_ff @(posedge aclk) begin
    if (!aresetn || wr_filt) begin
      smp_cnt_q <= '0;
    end else if (in_valid) begin
      smp_cnt_q <= step_tick ? 5'd0 : smp_cnt_q + 5'd1;
    end
  end

  // Mono mix: halve the sum so it cannot clip
  assign sum = {in_left[23], in_left} + {in_right[23], in_right};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mix_vld_q <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      mix_vld_q <= in_valid;
      out_valid <= mix_vld_q;
    end
  end

  // Per channel: mix select, gain ramp and gain stage
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic [7:0] vol;
    logic [7:0] tgt;
    logic [7:0] cur_q;
    pmg_smp_t   mix_q;
    pmg_smp_t   gout;

    assign vol = vol_q[ch*8 +: 8];
    assign tgt = eff_mute ? 8'h00 : vol;
    assign cur_all[ch*8 +: 8] = cur_q;
    assign tgt_all[ch*8 +: 8] = tgt;

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        mix_q <= '0;
      end else if (in_valid) begin
        if (filt_q[`PMG_MONO_BIT]) begin
          mix_q <= sum[24:1];
        end else begin
          mix_q <= (ch == 0) ? in_left : in_right;
        end
      end
    end

    // Muting always ramps; un-muting ramps only when selected
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cur_q <= 8'h00;
      end else if (tgt < cur_q) begin
        if (step_tick) begin
          cur_q <= cur_q - 8'h01;
        end
      end else if (tgt > cur_q) begin
        if (!filt_q[`PMG_URAMP_BIT]) begin
          cur_q <= tgt;
        end else if (step_tick) begin
          cur_q <= cur_q + 8'h01;
        end
      end
    end

    pmg_gain_stage u_gain (
      .aclk    (aclk),
      .aresetn (aresetn),
      .in_vld  (mix_vld_q),
      .in_smp  (mix_q),
      .code    (cur_q),
      .out_smp (gout)
    );
  end

  assign mix_l     = g_ch[0].mix_q;
  assign mix_r     = g_ch[1].mix_q;
  assign out_left  = g_ch[0].gout;
  assign out_right = g_ch[1].gout;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_MUTE_RAMP: assert property (
    filt_q[`PMG_MUTE_BIT] && cur_all[7:0] != 8'h00 && step_tick
    |=> cur_all[7:0] == $past(cur_all[7:0]) - 8'h01)
    else $error("soft mute did not step down");

  AST_RST_MUTED: assert property (
    !$past(aresetn) |-> filt_q[`PMG_MUTE_BIT] && cur_all == 16'h0000)
    else $error("path not muted after reset");

  AST_UNMUTE_JUMP: assert property (
    !filt_q[`PMG_URAMP_BIT] && tgt_all[7:0] > cur_all[7:0]
    |=> cur_all[7:0] == $past(tgt_all[7:0]))
    else $error("instant un-mute did not jump");

  AST_TICK_RATE: assert property (
    step_tick |-> smp_cnt_q == (filt_q[`PMG_RATE_BIT] ? 5'd31 : 5'd1))
    else $error("gain step at wrong sample count");

  AST_STEP_ONLY: assert property (
    cur_all[15:8] < $past(cur_all[15:8])
    |-> $past(step_tick) && cur_all[15:8] == $past(cur_all[15:8]) - 8'h01)
    else $error("gain fell faster than one step per tick");

  AST_RST_GATE: assert property (
    !$past(aresetn) |-> gate_q == 16'h0068)
    else $error("gate control reset value wrong");

  AST_GATE_MUTES: assert property (
    gate_act && cur_all[7:0] != 8'h00 && step_tick
    |=> cur_all[7:0] == $past(cur_all[7:0]) - 8'h01)
    else $error("active gate did not step down");

  AST_MONO_SAME: assert property (
    in_valid && filt_q[`PMG_MONO_BIT] |=> mix_l == mix_r)
    else $error("mono mix differs per channel");

  AST_MONO_HALF: assert property (
    in_valid && filt_q[`PMG_MONO_BIT]
    |=> mix_l == 24'((25'($past(in_left)) + 25'($past(in_right))) >>> 1))
    else $error("mono mix not halved sum");

  COV_MUTE_DONE: cover property ($fell(|cur_all) && filt_q[`PMG_MUTE_BIT]);
  COV_GATE_ON:   cover property ($rose(gate_act));
  COV_RAMP_UP:   cover property (filt_q[`PMG_URAMP_BIT] && cur_all[7:0] > $past(cur_all[7:0]));
  COV_MONO:      cover property (mix_vld_q && filt_q[`PMG_MONO_BIT] && mix_l != 24'h000000);
endmodule : pmg_playback_path

// File: sim/pmg_smp_src.sv
// Sample source standing in for the interface receive logic
// Assumes aclk domain; one strobe every gap cycles while run is high
`timescale 1ns/1ps
module pmg_smp_src
  import pmg_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Bench control
  input  wire logic       run,
  input  wire logic [7:0] gap,
  input  wire pmg_smp_t   lvl_l,
  input  wire pmg_smp_t   lvl_r,
  // Sample stream
  output logic            in_valid,
  output pmg_smp_t        in_left,
  output pmg_smp_t        in_right
);
  logic [7:0] cnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_q    <= 8'h00;
      in_valid <= 1'b0;
    end else begin
      cnt_q    <= (cnt_q == gap - 8'h01) ? 8'h00 : cnt_q + 8'h01;
      in_valid <= (cnt_q == 8'h00);
    end
  end

  // Data toggles between strobes so stale values never look valid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_left  <= 24'h000000;
      in_right <= 24'h000000;
    end else if (run && cnt_q == 8'h00) begin
      in_left  <= lvl_l;
      in_right <= lvl_r;
    end else begin
      in_left  <= ~in_left;
      in_right <= ~in_right;
    end
  end
endmodule : pmg_smp_src

// File: sim/tb.sv
// Self-checking bench for the playback mute, gate and mono path
// Assumes the sample source model and short hold counts
`timescale 1ns/1ps
module tb;
  import pmg_pkg::*;
  logic        aclk, aresetn, run;
  logic [11:0] awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [7:0]  gap;
  logic        in_valid, out_valid;
  pmg_smp_t    lvl_l, lvl_r, in_left, in_right, out_left, out_right;
  int          n_checks, n_mismatch;

  pmg_smp_src u_src (.aclk(aclk), .aresetn(aresetn), .run(run), .gap(gap), .lvl_l(lvl_l),
    .lvl_r(lvl_r), .in_valid(in_valid), .in_left(in_left), .in_right(in_right));

  // Short hold counts keep the gate scenarios brief
  pmg_playback_path #(.HOLD0_CYC(100), .HOLD1_CYC(200), .HOLD2_CYC(300), .HOLD3_CYC(400)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .in_valid(in_valid),
    .in_left(in_left), .in_right(in_right), .out_valid(out_valid), .out_left(out_left),
    .out_right(out_right));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_smp(input pmg_smp_t got, input pmg_smp_t exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_smp

  // Address and data offered together, each released once taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge aclk);
    bready <= 1'b0;
    chk_word({30'h0, bresp}, {30'h0, er});
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic set_lvl(input pmg_smp_t l, input pmg_smp_t r);
    @(posedge aclk);
    lvl_l <= l;
    lvl_r <= r;
  endtask : set_lvl

  task automatic wait_smp(input int n);
    repeat (n) begin
      do @(posedge aclk); while (!in_valid);
    end
  endtask : wait_smp

  task automatic get_out(output pmg_smp_t l, output pmg_smp_t r);
    do @(posedge aclk); while (!out_valid);
    l = out_left;
    r = out_right;
  endtask : get_out

  // Status word: left code, right code, gate active in bit 16
  task automatic stat_code(input logic [7:0] lo, input logic [7:0] hi);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(12'h414, d, r);
    chk_word({31'h0, d[7:0] >= lo && d[7:0] <= hi}, 32'h1);
  endtask : stat_code

  task automatic stat_is(input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(12'h414, d, r);
    chk_word(d, e);
  endtask : stat_is

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    pmg_smp_t    l, rr;
    axi_rd(12'h420, d, r);
    chk_word(d, 32'h0200);
    axi_rd(12'h430, d, r);
    chk_word(d, 32'h0068);
    axi_rd(12'h440, d, r);
    chk_word({d[29:0], r}, 32'h2);
    axi_wr(12'h414, 32'h0, 2'b10);
    set_lvl(24'sd5000, -24'sd7000);
    wait_smp(3);
    get_out(l, rr);
    chk_smp(l, 24'sd0);
  endtask : t_reset

  task automatic t_mute_cycle();
    pmg_smp_t l, r;
    axi_wr(12'h420, 32'h0000, 2'b00);
    stat_is(32'h0000c0c0);
    wait_smp(3);
    get_out(l, r);
    chk_smp(r, -24'sd7000);
    axi_wr(12'h420, 32'h0200, 2'b00);
    wait_smp(40);
    stat_code(8'hab, 8'had);
    wait_smp(400);
    stat_is(32'h0);
    get_out(l, r);
    chk_smp(l, 24'sd0);
    axi_wr(12'h420, 32'h0010, 2'b00);
    wait_smp(40);
    stat_code(8'h13, 8'h15);
    wait_smp(400);
    stat_is(32'h0000c0c0);
    axi_wr(12'h420, 32'h0230, 2'b00);
    wait_smp(64);
    stat_code(8'hbd, 8'hbf);
    axi_wr(12'h420, 32'h0000, 2'b00);
    stat_is(32'h0000c0c0);
  endtask : t_mute_cycle

  task automatic t_mono();
    logic [31:0] d;
    logic [1:0]  rs;
    pmg_smp_t    l, r;
    axi_wr(12'h420, 32'h0080, 2'b00);
    axi_rd(12'h420, d, rs);
    chk_word(d, 32'h0080);
    set_lvl(24'sd1001, -24'sd4000);
    wait_smp(4);
    get_out(l, r);
    chk_smp(l, -24'sd1500);
    chk_smp(r, -24'sd1500);
    axi_wr(12'h420, 32'h0000, 2'b00);
    // Right channel 6 dB down proves each side follows its own volume
    axi_wr(12'h410, 32'h0000b0c0, 2'b00);
    wait_smp(40);
    stat_is(32'h0000b0c0);
    get_out(l, r);
    chk_smp(l, 24'sd1001);
    chk_smp(r, -24'sd2000);
    axi_wr(12'h410, 32'h0000c0c0, 2'b00);
    axi_rd(12'h410, d, rs);
    chk_word(d, 32'h0000c0c0);
  endtask : t_mono

  // Negative loud samples prove the gate looks at magnitude
  task automatic t_gate();
    logic [31:0] d;
    logic [1:0]  r;
    for (int h = 0; h < 4; h++) begin
      axi_wr(12'h430, {25'h0, h[1:0], 5'h01}, 2'b00);
      set_lvl(24'sd100, -24'sd20000);
      wait_smp(3);
      set_lvl(24'sd100, -24'sd100);
      repeat (100 * (h + 1) - 20) @(posedge aclk);
      axi_rd(12'h414, d, r);
      chk_word({31'h0, d[16]}, 32'h0);
      repeat (40) @(posedge aclk);
      axi_rd(12'h414, d, r);
      chk_word({31'h0, d[16]}, 32'h1);
    end
    wait_smp(40);
    stat_code(8'h00, 8'hbf);
    set_lvl(-24'sd20000, 24'sd0);
    wait_smp(4);
    stat_is(32'h0000c0c0);
    set_lvl(24'sd100, -24'sd100);
    axi_wr(12'h430, 32'h000f, 2'b00);
    repeat (200) @(posedge aclk);
    axi_rd(12'h414, d, r);
    chk_word({31'h0, d[16]}, 32'h0);
    axi_wr(12'h430, 32'h000d, 2'b00);
    repeat (200) @(posedge aclk);
    axi_rd(12'h414, d, r);
    chk_word({31'h0, d[16]}, 32'h1);
    axi_wr(12'h430, 32'h000c, 2'b00);
    repeat (200) @(posedge aclk);
    axi_rd(12'h414, d, r);
    chk_word({31'h0, d[16]}, 32'h0);
  endtask : t_gate

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Scenarios need about 6000 cycles; allow a wide margin
  initial begin
    #300000;
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    n_checks = 0;
    n_mismatch = 0;
    aresetn = 1'b0;
    run = 1'b0;
    gap = 8'd4;
    lvl_l = 24'sd0;
    lvl_r = 24'sd0;
    awaddr = 12'h0;
    araddr = 12'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    run <= 1'b1;
    t_reset();
    t_mute_cycle();
    t_mono();
    t_gate();
    tally_and_finish();
  end
endmodule : tb
